/* File: shared/tlic_map.vh */
`ifndef TLIC_MAP_VH
`define TLIC_MAP_VH
// ****************************************************************
// Register byte offsets on the AXI4-Lite slave.
// ****************************************************************
`define TLIC_OFF_INTERRUPT_CONTROL_MAIN   8'h00
`define TLIC_OFF_RESETCTL 8'h04
`define TLIC_OFF_CORESTAT 8'h08
`define TLIC_OFF_FLAG0    8'h10
`define TLIC_OFF_EN0      8'h30
`define TLIC_OFF_PRIO0    8'h50
// ****************************************************************
// Field positions.
// ****************************************************************
`define TLIC_BIT_HIGHEN   7
`define TLIC_BIT_LOWEN    6
`define TLIC_BIT_EXT0EN   4
`define TLIC_BIT_EXT0FLG  1
`define TLIC_BIT_PRIOEN   7
// ****************************************************************
// Reset values and vectors.
// ****************************************************************
`define TLIC_RST_INTERRUPT_CONTROL_MAIN   8'h00
`define TLIC_RST_BYTE     8'h00
`define TLIC_VEC_HIGH     16'h0008
`define TLIC_VEC_LOW      16'h0018
// ****************************************************************
// Timing: latency in instruction cycles, pipeline stages used.
// ****************************************************************
`define TLIC_LAT_CYCLES   3
`define TLIC_SYNC_STAGES  2
`define TLIC_AXI_OKAY     2'b00
`define TLIC_AXI_DECERR   2'b11
`endif

/* File: src/tlic_sync.v */
`timescale 1ns/10ps
// ****************************************************************
// Two flip-flop level synchroniser, one lane per bit.
// ****************************************************************
module tlic_sync #(
    parameter WIDTH = 8
) (
    core_clk,
    nrst,
    asyncIn,
    syncOut
);
    input  wire             core_clk;
    input  wire             nrst;
    input  wire [WIDTH-1:0] asyncIn;
    output reg  [WIDTH-1:0] syncOut;

    reg [WIDTH-1:0] meta_reg;

    // The first stage feeds only the second stage.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= {WIDTH{1'b0}};
            syncOut  <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= asyncIn;
            syncOut  <= meta_reg;
        end
    end
endmodule // tlic_sync

/* File: src/tlic_top.v */
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "tlic_map.vh"
// What this block does
// - Sources high or low; pin zero always high.
// - Priority mode vectors: high 0008h, low 0018h.
// - High request pre-empts running low service.
// - Each peripheral source has flag, enable, priority bits.
// - Priority enable bit turns on priority mode.
// - Priority enable clear: priority bits ignored.
// - Compatibility: peripherals need both global enables.
// - Compatibility mode: every vector is 0008h.
// - High enable gates all sources in priority.
// - Low sources need both level enables.
// - Eligible source vectors at once by priority.
// - Entry clears the applicable global enable.
// - No low service while high service runs.
// - Entry pushes return address, loads vector.
// - Return instruction sets the applicable enable.
// - Pin interrupts show three-to-four-cycle latency.
// - Flags set regardless of any enable.
// - Five flag, enable and priority registers.
// - High enable bit 7, low enable bit 6.
module tlic_top #(
    parameter NREG = 5
) (
    core_clk,
    nrst,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    extPin,
    periphEvent,
    returnAddr,
    returnFromIntInstr,
    intTake,
    vectorAddr,
    pushAddr,
    highActive,
    lowActive
);
    input  wire                core_clk;
    input  wire                nrst;
    input  wire [7:0]          s_axi_awaddr;
    input  wire                s_axi_awvalid;
    output reg                 s_axi_awready;
    input  wire [31:0]         s_axi_wdata;
    input  wire [3:0]          s_axi_wstrb;
    input  wire                s_axi_wvalid;
    output reg                 s_axi_wready;
    output reg  [1:0]          s_axi_bresp;
    output reg                 s_axi_bvalid;
    input  wire                s_axi_bready;
    input  wire [7:0]          s_axi_araddr;
    input  wire                s_axi_arvalid;
    output reg                 s_axi_arready;
    output reg  [31:0]         s_axi_rdata;
    output reg  [1:0]          s_axi_rresp;
    output reg                 s_axi_rvalid;
    input  wire                s_axi_rready;
    input  wire                extPin;
    input  wire [8*NREG-1:0]   periphEvent;
    input  wire [15:0]         returnAddr;
    input  wire                returnFromIntInstr;
    output reg                 intTake;
    output reg  [15:0]         vectorAddr;
    output reg  [15:0]         pushAddr;
    output reg                 highActive;
    output reg                 lowActive;

    // ************************************************************
    // Register state.
    // ************************************************************
    reg [7:0]        intconReg;
    reg              prioEnReg;
    reg [8*NREG-1:0] flagReg;
    reg [8*NREG-1:0] enReg;
    reg [8*NREG-1:0] prioReg;
    reg              pinPrevReg;
    wire             pinSync;

    // The external pin crosses into the core clock first.
    // Only the second synchroniser stage is read past this point.
    tlic_sync #(.WIDTH(1)) uPinSync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .asyncIn  (extPin),
        .syncOut  (pinSync)
    );

    // ************************************************************
    // Pin edge detection.
    // ************************************************************
    // The detector starts low, the idle level of the pin, so leaving
    // reset never fakes an edge. Two synchroniser stages and this
    // detector set the flag three edges after the pin and enter one
    // edge later, whatever instruction the core is executing.
    wire pinEvent = pinSync & ~pinPrevReg;

    // Previous synchronised level for the rising edge test.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pinPrevReg <= 1'b0;
        end else begin
            pinPrevReg <= pinSync;
        end
    end

    // ************************************************************
    // Request qualification.
    // ************************************************************
    wire highEn  = intconReg[`TLIC_BIT_HIGHEN];
    wire lowEn   = intconReg[`TLIC_BIT_LOWEN];
    wire pinReq  = intconReg[`TLIC_BIT_EXT0FLG] &
                   intconReg[`TLIC_BIT_EXT0EN];
    // A source asks only while its flag and its enable are both set.
    wire [8*NREG-1:0] pReq = flagReg & enReg;
    // Peripheral requests split by their priority select.
    wire periHighReq = |(pReq & prioReg);
    wire periLowReq  = |(pReq & ~prioReg);
    // Pin source has no priority bit and is always high.
    wire anyHigh = pinReq | (prioEnReg & periHighReq);
    wire anyLow  = prioEnReg & periLowReq;
    // Compatibility mode treats every entry as the single level.
    wire compReq = pinReq | (lowEn & (|pReq));
    wire takeComp = ~prioEnReg & highEn & compReq & ~highActive;
    wire takeHigh = prioEnReg & highEn & anyHigh & ~highActive;
    // Low waits behind any high request and any high service.
    wire takeLow  = prioEnReg & highEn & lowEn & anyLow & ~anyHigh &
                    ~highActive & ~lowActive;

    // ************************************************************
    // AXI4-Lite slave.
    // ************************************************************
    // Write channel holding state; each channel is taken on its own.
    reg        awHeld;
    reg        wHeld;
    reg [7:0]  awAddrReg;
    reg [31:0] wDataReg;
    reg        wStrb0Reg;
    wire       doWrite = awHeld & wHeld & ~s_axi_bvalid;
    wire [7:0] wByte = wDataReg[7:0];
    wire [7:0] wIdx = (awAddrReg - `TLIC_OFF_FLAG0) >> 2;
    // Mapped write addresses; anything else answers DECERR.
    wire       wMapped = (awAddrReg == `TLIC_OFF_INTERRUPT_CONTROL_MAIN) |
                         (awAddrReg == `TLIC_OFF_RESETCTL) |
                         (awAddrReg == `TLIC_OFF_CORESTAT) |
                         (awAddrReg[1:0] == 2'b00 &&
                          awAddrReg >= `TLIC_OFF_FLAG0 &&
                          awAddrReg < `TLIC_OFF_PRIO0 + 8'd4*NREG &&
                          wIdx[2:0] < NREG);

    // Write address and data are taken independently.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddrReg     <= 8'h00;
            wDataReg      <= 32'h00000000;
            wStrb0Reg     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TLIC_AXI_OKAY;
        end else begin
            s_axi_awready <= ~awHeld & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~wHeld & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                awHeld    <= 1'b1;
                awAddrReg <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wHeld     <= 1'b1;
                wDataReg  <= s_axi_wdata;
                wStrb0Reg <= s_axi_wstrb[0];
            end
            // The response follows once both halves are held.
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wMapped ? `TLIC_AXI_OKAY : `TLIC_AXI_DECERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // AXI4-Lite read channel.
    // ************************************************************
    // Read decode of the control registers and the three register arrays. An unmapped address
    // reads zero and answers DECERR.
    reg [7:0]  rByte;
    reg        rOk;
    integer    k;
    always @* begin
        rByte = 8'h00;
        rOk   = 1'b1;
        case (s_axi_araddr)
            `TLIC_OFF_INTERRUPT_CONTROL_MAIN:   rByte = intconReg;
            `TLIC_OFF_RESETCTL: rByte = {prioEnReg, 7'h00};
            `TLIC_OFF_CORESTAT: rByte = {6'h00, highActive, lowActive};
            default: begin
                rOk = 1'b0;
                for (k = 0; k < NREG; k = k + 1) begin
                    if (s_axi_araddr == `TLIC_OFF_FLAG0 + 4*k) begin
                        rByte = flagReg[8*k +: 8];
                        rOk   = 1'b1;
                    end
                    if (s_axi_araddr == `TLIC_OFF_EN0 + 4*k) begin
                        rByte = enReg[8*k +: 8];
                        rOk   = 1'b1;
                    end
                    if (s_axi_araddr == `TLIC_OFF_PRIO0 + 4*k) begin
                        rByte = prioReg[8*k +: 8];
                        rOk   = 1'b1;
                    end
                end
            end
        endcase
    end

    // Read channel answers one cycle after the address is taken.
    // Data is captured from the decode while the address stands.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `TLIC_AXI_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rByte};
                s_axi_rresp  <= rOk ? `TLIC_AXI_OKAY : `TLIC_AXI_DECERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Control, flag and service state.
    // ************************************************************
    wire wrOn = doWrite & wStrb0Reg;
    wire wrIntcon = wrOn & (awAddrReg == `TLIC_OFF_INTERRUPT_CONTROL_MAIN);
    // Next values of the bits that hardware and software both change.
    reg  [7:0] intconNext;
    reg  [8*NREG-1:0] flagNext;
    integer j;
    integer n;

    // Software writes first; hardware sets and clears win over them.
    always @* begin
        intconNext = wrIntcon ? wByte : intconReg;
        flagNext   = flagReg;
        for (j = 0; j < NREG; j = j + 1) begin
            if (wrOn && awAddrReg == `TLIC_OFF_FLAG0 + 4*j)
                flagNext[8*j +: 8] = wByte;
        end
        // Hardware never clears a flag; service software must.
        flagNext = flagNext | periphEvent;
        if (pinEvent)
            intconNext[`TLIC_BIT_EXT0FLG] = 1'b1;
        if (returnFromIntInstr) begin
            // Return restores the level whose service is ending.
            if (!prioEnReg || highActive)
                intconNext[`TLIC_BIT_HIGHEN] = 1'b1;
            else if (lowActive)
                intconNext[`TLIC_BIT_LOWEN] = 1'b1;
        end
        // Entry clears the enable of the level it enters.
        if (takeComp | takeHigh)
            intconNext[`TLIC_BIT_HIGHEN] = 1'b0;
        if (takeLow)
            intconNext[`TLIC_BIT_LOWEN] = 1'b0;
    end

    // ************************************************************
    // Register updates and the core handshake.
    // ************************************************************
    // Every register of the control state is written in this process.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            intconReg  <= `TLIC_RST_INTERRUPT_CONTROL_MAIN;
            prioEnReg  <= 1'b0;
            flagReg    <= {NREG{`TLIC_RST_BYTE}};
            enReg      <= {NREG{`TLIC_RST_BYTE}};
            prioReg    <= {NREG{`TLIC_RST_BYTE}};
            highActive <= 1'b0;
            lowActive  <= 1'b0;
            intTake    <= 1'b0;
            vectorAddr <= 16'h0000;
            pushAddr   <= 16'h0000;
        end else begin
            intconReg <= intconNext;
            flagReg   <= flagNext;
            if (wrOn && awAddrReg == `TLIC_OFF_RESETCTL)
                prioEnReg <= wByte[`TLIC_BIT_PRIOEN];
            // Software-only registers: enables and priority selects.
            for (n = 0; n < NREG; n = n + 1) begin
                if (wrOn && awAddrReg == `TLIC_OFF_EN0 + 4*n)
                    enReg[8*n +: 8] <= wByte;
                if (wrOn && awAddrReg == `TLIC_OFF_PRIO0 + 4*n)
                    prioReg[8*n +: 8] <= wByte;
            end
            // Entry: capture the return address and pick the vector.
            intTake <= takeComp | takeHigh | takeLow;
            if (takeComp | takeHigh | takeLow)
                pushAddr <= returnAddr;
            if (takeComp | takeHigh)
                vectorAddr <= `TLIC_VEC_HIGH;
            else if (takeLow)
                vectorAddr <= `TLIC_VEC_LOW;
            // Service levels: entry sets one, the matching return clears it.
            if (takeComp | takeHigh)
                highActive <= 1'b1;
            else if (returnFromIntInstr & highActive)
                highActive <= 1'b0;
            if (takeLow)
                lowActive <= 1'b1;
            else if (returnFromIntInstr & ~highActive)
                lowActive <= 1'b0;
        end
    end
endmodule // tlic_top

/* File: dv/tlic_top_asserts.sv */
`timescale 1ns/10ps
// ********************
// Entry, return and read answer checks on the top ports.
// ********************
module tlic_top_asserts (
    input wire        core_clk,
    input wire        nrst,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire [15:0] returnAddr,
    input wire        returnFromIntInstr,
    input wire        intTake,
    input wire [15:0] vectorAddr,
    input wire [15:0] pushAddr,
    input wire        highActive,
    input wire        lowActive
);
    // All checks run on the core clock and rest during reset.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    AST_VEC_LEGAL: assert property (
        intTake |-> vectorAddr inside {16'h0008, 16'h0018})
        else $error("illegal vector");
    AST_NO_TAKE_IN_HIGH: assert property (
        intTake |-> !$past(highActive))
        else $error("entry during high service");
    AST_PUSH_RETURN: assert property (
        intTake |-> pushAddr == $past(returnAddr))
        else $error("wrong pushed address");
    AST_HIGH_ENTRY: assert property (
        intTake && vectorAddr == 16'h0008 |-> highActive ##1 !intTake)
        else $error("high entry state wrong");
    AST_LOW_ENTRY: assert property (
        intTake && vectorAddr == 16'h0018 |-> lowActive && !highActive)
        else $error("low entry state wrong");
    AST_VEC_HOLD: assert property (
        !intTake |-> $stable(vectorAddr))
        else $error("vector moved without entry");
    AST_RET_HIGH: assert property (
        returnFromIntInstr && highActive |=> !highActive)
        else $error("high return ignored");
    AST_RET_LOW: assert property (
        returnFromIntInstr && !highActive && lowActive |=> !lowActive)
        else $error("low return ignored");
    AST_READ_ANSWER: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");

    // Main scenarios seen.
    COV_HIGH: cover property (intTake && vectorAddr == 16'h0008);
    COV_LOW: cover property (intTake && vectorAddr == 16'h0018);
    COV_NEST: cover property (intTake && highActive && lowActive);
endmodule // tlic_top_asserts

bind tlic_top tlic_top_asserts u_chk (.core_clk(core_clk), .nrst(nrst),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .returnAddr(returnAddr),
    .returnFromIntInstr(returnFromIntInstr), .intTake(intTake),
    .vectorAddr(vectorAddr), .pushAddr(pushAddr),
    .highActive(highActive), .lowActive(lowActive));

/* File: dv/tlic_core_model.sv */
`timescale 1ns/10ps
// ********************
// Core sequencer model: counter, return stack, return pulse.
// ********************
module tlic_core_model (
    input  wire         core_clk,
    input  wire         nrst,
    input  wire         intTake,
    input  wire  [15:0] vectorAddr,
    input  wire  [15:0] pushAddr,
    input  wire         retReq,
    output logic [15:0] returnAddr,
    output logic        returnFromIntInstr
);
    logic [15:0] stackQ[$];

    // Steps the counter, branches on entry, resumes on return.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            returnAddr <= 16'h0100;
            returnFromIntInstr <= 1'b0;
        end else begin
            returnFromIntInstr <= retReq;
            if (intTake) begin
                stackQ.push_back(pushAddr);
                returnAddr <= vectorAddr;
            end else if (returnFromIntInstr && stackQ.size() > 0) begin
                returnAddr <= stackQ.pop_back();
            end else begin
                returnAddr <= returnAddr + 16'h0001;
            end
        end
    end
endmodule // tlic_core_model

/* File: dv/two_level_interrupt_controller_tb_top.sv */
`timescale 1ns/10ps
// ********************
// Bench with a register mirror and an entry model.
// ********************
module two_level_interrupt_controller_tb_top;
    logic        core_clk = 1'b0, nrst = 1'b0, extPin = 1'b0, retReq = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [39:0] periphEvent = 40'h0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire         s_axi_arready, s_axi_rvalid, returnFromIntInstr;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [15:0] returnAddr, vectorAddr, pushAddr;
    wire         intTake, highActive, lowActive;
    logic [7:0]  m [0:63];
    logic [15:0] lastRa, ev;
    logic        hiE;
    integer      seed = 32'h7d273b43;
    int          nErrors = 0, totalChecks = 0, takes = 0;
    int          i, j, r, b, h, t0, lat;

    tlic_top #(.NREG(5)) dut (.core_clk, .nrst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready(1'b1), .extPin, .periphEvent, .returnAddr,
        .returnFromIntInstr, .intTake, .vectorAddr, .pushAddr,
        .highActive, .lowActive);
    tlic_core_model u_core (.core_clk, .nrst, .intTake, .vectorAddr,
        .pushAddr, .retReq, .returnAddr, .returnFromIntInstr);

    // Free-running core clock.
    always #10 core_clk = ~core_clk;

    function automatic bit isMap(input logic [7:0] a);
        return a < 8'h0c || (a >= 8'h10 && a < 8'h24) ||
            (a >= 8'h30 && a < 8'h44) || (a >= 8'h50 && a < 8'h64);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic endSim();
        $display("checks %0d mismatches %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Single register writes only, never block moves.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, isMap(a) ? 2'b00 : 2'b11);
        if (isMap(a) && a != 8'h08 && s_axi_wstrb[0]) m[a[7:2]] = d[7:0];
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rresp, isMap(a) ? 2'b00 : 2'b11);
        chk(s_axi_rdata, isMap(a) ? {24'h0, m[a[7:2]]} : 32'h0);
    endtask

    task automatic evt(input logic [39:0] v);
        periphEvent <= v;
        for (int k = 0; k < 5; k++) m[4+k] = m[4+k] | v[8*k +: 8];
        @(posedge core_clk);
        periphEvent <= 40'h0;
    endtask

    task automatic ret();
        retReq <= 1'b1;
        @(posedge core_clk);
        retReq <= 1'b0;
        cyc(2);
    endtask

    // Address handed to the core just before each edge.
    always @(posedge core_clk) lastRa <= returnAddr;

    // Mirrors entry and return effects and checks every entry.
    always @(negedge core_clk) begin
        if (nrst && intTake === 1'b1) begin
            hiE = m[0][4] & m[0][1];
            for (j = 0; j < 5; j++)
                hiE = hiE | (|(m[4+j] & m[12+j] & m[20+j]));
            ev = (!m[1][7] || hiE) ? 16'h0008 : 16'h0018;
            chk(vectorAddr, ev);
            chk(pushAddr, lastRa);
            takes++;
            m[0][ev == 16'h0018 ? 6 : 7] = 1'b0;
            m[2][ev == 16'h0018 ? 0 : 1] = 1'b1;
        end
        if (nrst && returnFromIntInstr === 1'b1) begin
            hiE = !m[1][7] || m[2][1];
            m[0][hiE ? 7 : 6] = 1'b1;
            m[2][hiE ? 1 : 0] = 1'b0;
        end
    end

    // Stops a hung run.
    initial begin
        #400000;
        nErrors++;
        endSim();
    end

    // Main sequence.
    initial begin
        for (i = 0; i < 64; i++) m[i] = 8'h00;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        for (i = 0; i < 26; i++) rd(8'(i * 4));
        rd(8'hfc);
        wr(8'hfc, 32'h1);
        wr(8'h08, 32'hff);
        rd(8'h08);
        // A write without byte lane zero answers but changes nothing.
        s_axi_wstrb <= 4'he;
        wr(8'h00, 32'hff);
        s_axi_wstrb <= 4'hf;
        rd(8'h00);
        for (r = 0; r < 5; r++) begin
            wr(8'h30 + 8'(4 * r), $random(seed));
            wr(8'h50 + 8'(4 * r), $random(seed));
            rd(8'h30 + 8'(4 * r));
            rd(8'h50 + 8'(4 * r));
            wr(8'h30 + 8'(4 * r), 32'h0);
        end
        b = {$random(seed)} % 40;
        h = (b + 8) % 40;
        evt(40'h1 << b);
        cyc(10);
        chk(takes, 0);
        rd(8'h10 + 8'(4 * (b / 8)));
        wr(8'h30 + 8'(4 * (b / 8)), 32'h1 << (b % 8));
        wr(8'h50 + 8'(4 * (b / 8)), 32'h0);
        wr(8'h00, 32'h40);
        cyc(10);
        wr(8'h00, 32'h80);
        cyc(10);
        chk(takes, 0);
        wr(8'h00, 32'hc0);
        cyc(10);
        chk(takes, 1);
        rd(8'h00);
        rd(8'h08);
        wr(8'h10 + 8'(4 * (b / 8)), 32'h0);
        ret();
        cyc(10);
        rd(8'h00);
        wr(8'h04, 32'h80);
        wr(8'h30 + 8'(4 * (h / 8)), 32'h1 << (h % 8));
        wr(8'h50 + 8'(4 * (h / 8)), 32'h1 << (h % 8));
        wr(8'h00, 32'h40);
        evt((40'h1 << b) | (40'h1 << h));
        cyc(10);
        chk(takes, 1);
        wr(8'h00, 32'hc0);
        cyc(10);
        chk(takes, 2);
        wr(8'h10 + 8'(4 * (h / 8)), 32'h0);
        ret();
        cyc(10);
        chk(takes, 3);
        rd(8'h00);
        evt(40'h1 << h);
        cyc(10);
        chk(takes, 4);
        rd(8'h08);
        wr(8'h10 + 8'(4 * (h / 8)), 32'h0);
        wr(8'h10 + 8'(4 * (b / 8)), 32'h0);
        ret();
        ret();
        cyc(10);
        rd(8'h00);
        wr(8'h00, 32'hd0);
        extPin <= 1'b1;
        m[0][1] = 1'b1;
        t0 = takes;
        lat = 0;
        do begin
            cyc(1);
            lat++;
        end while (intTake !== 1'b1 && lat < 20);
        // Entry is seen one edge after it is launched.
        chk(lat >= 4 && lat <= 5, 1);
        chk(takes, t0 + 1);
        wr(8'h00, 32'h50);
        extPin <= 1'b0;
        ret();
        cyc(4);
        rd(8'h00);
        endSim();
    end
endmodule // two_level_interrupt_controller_tb_top
